// file: bench/dioptm_assertions.sv
// Purpose: Port checks for the digital port and pacer timer block.
// Assumes: Bound to dioptm_top; sees its ports only.
// Notes: One clock domain.
`timescale 1ns/1ps
module dioptm_assertions import dioptm_pkg::*; (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic nrst,
  // Watched ports.
  input wire logic swInit,
  input wire dioptm_req_t req,
  input wire logic acqActive,
  input wire logic [7:0] rdData,
  input wire logic rdValid,
  input wire logic data_lost_event,
  input wire logic [PORT_W-1:0] parallelOutLines,
  input wire logic [PORT_W-1:0] upper_mux_select_lines,
  input wire logic gain_extension_line,
  input wire logic adPace
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence muxWr; req.wrReq && req.wrPort == 2'h1 && !acqActive && !swInit; endsequence
  sequence outClr; parallelOutLines == OUT_RST && upper_mux_select_lines == OUT_RST && !gain_extension_line; endsequence
  rd_answer_a: assert property (req.rdReq |=> rdValid) else $error("read answer missing");
  rd_zero_fill_a: assert property (req.rdReq && req.rdPort == 2'h0 |=> rdData[7:4] == 4'h0) else $error("fill");
  rd_unused_a: assert property (req.rdReq && req.rdPort[0] |=> rdData == 8'h00) else $error("unused port read");
  out_write_a: assert property (req.wrReq && req.wrPort == 2'h0 && !swInit |=>
    parallelOutLines == $past(req.wrData[3:0])) else $error("port 0 write");
  mux_write_a: assert property (muxWr |=>
    {gain_extension_line, upper_mux_select_lines} == $past(req.wrData[4:0])) else $error("mux write");
  mux_hold_a: assert property (!swInit && !(req.wrReq && req.wrPort == 2'h1) |=>
    $stable({gain_extension_line, upper_mux_select_lines})) else $error("mux hold");
  init_clear_a: assert property (swInit |=> outClr) else $error("init clear");
  no_lost_a: assert property (!data_lost_event) else $error("lost event");
  pace_pulse_a: assert property (adPace |=> !adPace) else $error("pace width");
endmodule // dioptm_assertions
bind dioptm_top dioptm_assertions u_chk (.sys_clk, .nrst, .swInit, .req, .acqActive, .rdData, .rdValid,
  .data_lost_event, .parallelOutLines, .upper_mux_select_lines, .gain_extension_line, .adPace);

// file: bench/test_digital_io_port_and_pacer_timer.sv
// Purpose: Self-checking bench for dioptm_top.
// Assumes: 40 MHz clock; inputs change 2 ns after the rising edge.
// Notes: Random data from a bench shift register.
`timescale 1ns/1ps
module test_digital_io_port_and_pacer_timer;
  import dioptm_pkg::*;
  logic sys_clk = 0, nrst = 0, swInit = 0, acqStart = 0, acqAbort = 0, trigNegEdge = 0, trigEnable = 0;
  logic sampleDone = 0, trigger_input_line = 0, rdValid, acqActive, data_lost_event, gain_extension_line, adPace, daPace;
  dioptm_req_t req = '0;
  dioptm_tmr_t tmr = '0;
  logic [PORT_W-1:0] parallel_in_lines = '0, parallelOutLines, upper_mux_select_lines, expPar = '0;
  logic [7:0] rdData;
  logic [4:0] expMux = '0;
  logic [31:0] lfsr = 32'hf617;
  int errors = 0, num_checks = 0, i, t0;
  dioptm_top dut (.sys_clk, .nrst, .swInit, .req, .tmr, .acqStart, .acqAbort, .trigNegEdge, .trigEnable,
    .sampleDone, .rdData, .rdValid, .acqActive, .data_lost_event, .parallel_in_lines, .trigger_input_line,
    .parallelOutLines, .upper_mux_select_lines, .gain_extension_line, .adPace, .daPace);
  always #12.5 sys_clk = ~sys_clk;
  function automatic logic [31:0] nextRand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] expRead(input logic [1:0] p);
    return p == 2'h0 ? {4'h0, parallel_in_lines} : (p == 2'h2 ? {7'h00, trigger_input_line} : 8'h00);
  endfunction
  task automatic step(input int n = 1);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic doWrite(input logic [1:0] p, input logic [7:0] d);
    req.wrReq = 1;
    req.wrPort = p;
    req.wrData = d;
    if (p == 2'h0) expPar = d[3:0];
    if (p == 2'h1 && !acqActive) expMux = d[4:0];
    step();
    req.wrReq = 0;
    check("port0 out", {4'h0, expPar}, {4'h0, parallelOutLines});
    check("mux out", {3'h0, expMux}, {3'h0, gain_extension_line, upper_mux_select_lines});
  endtask
  task automatic doRead(input logic [1:0] p);
    step(3);
    req.rdReq = 1;
    req.rdPort = p;
    step();
    req.rdReq = 0;
    check("rd valid", 8'h01, {7'h00, rdValid});
    check("rd data", expRead(p), rdData);
  endtask
  task automatic pacePeriod(input logic da, input int exp);
    for (i = 0; i < 3; i++) begin
      t0 = $time;
      step();
      while (!(da ? daPace : adPace) && $time - t0 < 5000) step();
    end
    t0 = $time;
    step();
    while (!(da ? daPace : adPace) && $time - t0 < 5000) step();
    check("pace period", 8'(exp), 8'(($time - t0) / 25));
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #(25 * 5000);
    errors++;
    finish_test();
  end
  initial begin
    step(2);
    nrst = 1;
    check("reset out", 8'h00, {3'h0, gain_extension_line, parallelOutLines});
    check("reset mux", 8'h00, {4'h0, upper_mux_select_lines});
    for (int k = 0; k < 40; k++) begin
      lfsr = nextRand(lfsr);
      parallel_in_lines = lfsr[3:0];
      trigger_input_line = lfsr[5];
      doWrite(lfsr[19:18], lfsr[15:8]);
      doRead(lfsr[17:16]);
    end
    $display("test ports done");
    swInit = 1;
    expPar = '0;
    expMux = '0;
    doWrite(2'h2, 8'hFF);
    swInit = 0;
    doRead(2'h0);
    check("lost", 8'h00, {7'h00, data_lost_event});
    $display("test init done");
    tmr = '{1'b1, 16'h0002, 16'h0003, 16'h0001, 16'h0002, 16'h0001};
    step();
    tmr.load = 0;
    pacePeriod(1'b0, 2 * 3 * OSC_DIV);
    pacePeriod(1'b1, OSC_DIV);
    doWrite(2'h1, 8'h0A);
    acqStart = 1;
    step();
    acqStart = 0;
    step();
    check("active", 8'h01, {7'h00, acqActive});
    doWrite(2'h1, 8'h15);
    step(30);
    for (int k = 0; k < 2; k++) begin
      sampleDone = 1;
      step();
      sampleDone = 0;
      step(2);
      check("stop count", {7'h00, k == 0}, {7'h00, acqActive});
    end
    $display("test acquisition done");
    for (int k = 0; k < 2; k++) begin
      trigNegEdge = k[0];
      trigger_input_line = k[0];
      trigEnable = 1;
      step(3);
      acqStart = 1;
      step(3);
      check("trig wait", 8'h00, {7'h00, acqActive});
      trigger_input_line = !k[0];
      step(5);
      check("trig edge", 8'h01, {7'h00, acqActive});
      acqStart = 0;
      acqAbort = 1;
      step();
      acqAbort = 0;
    end
    $display("test trigger done");
    finish_test();
  end
endmodule // test_digital_io_port_and_pacer_timer

// file: verilog/dioptm_counter.sv
// Purpose: One 16-bit binary rate generator counter.
// Assumes: Clock enable tick comes from the same clock domain.
// Notes: Pulses out for one cycle when it reloads.
`timescale 1ns/1ps
module dioptm_counter import dioptm_pkg::*; #(
  parameter int W = CNT_W
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic nrst,
  // Control.
  input wire logic init,
  input wire logic load,
  input wire logic [W-1:0] loadVal,
  input wire logic tick,
  // Output.
  output logic pulse
);
  typedef struct packed {
    logic [W-1:0] reload;
    logic [W-1:0] cnt;
    logic pulse;
  } dioptm_cst_t;

  dioptm_cst_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.pulse = 1'b0;
    if (init) begin
      s_d.reload = W'(CNT_INIT);
      s_d.cnt = W'(CNT_INIT);
    end else if (load) begin
      s_d.reload = loadVal;
      s_d.cnt = loadVal;
    end else if (tick) begin
      if (s_q.cnt <= W'(CNT_ONE)) begin
        s_d.cnt = s_q.reload;
        s_d.pulse = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt - W'(CNT_ONE);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '{reload: W'(CNT_INIT), cnt: W'(CNT_INIT), pulse: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign pulse = s_q.pulse;
endmodule // dioptm_counter

// file: verilog/dioptm_pkg.sv
// Purpose: Shared constants and carrier types for the digital port and pacer timer block.
// Assumes: One 40 MHz system clock; no software-visible register map.
// Notes: The 5 MHz counter clock is derived from the system clock by a tick divider.
package dioptm_pkg;
  localparam int PORT_W = 4;
  localparam int CNT_W = 16;
  localparam int SYS_CLK_HZ = 40000000;
  localparam int OSC_HZ = 5000000;
  localparam int OSC_DIV = SYS_CLK_HZ / OSC_HZ;
  localparam logic [CNT_W-1:0] CNT_INIT = 16'hFFFF;
  localparam logic [PORT_W-1:0] OUT_RST = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

  typedef enum logic [1:0] {
    DIOPTM_IDLE = 2'b00,
    DIOPTM_DELAY = 2'b01,
    DIOPTM_RUN = 2'b10
  } dioptm_acq_t;

  // Host request group for the digital ports.
  typedef struct packed {
    logic rdReq;
    logic [1:0] rdPort;
    logic wrReq;
    logic [1:0] wrPort;
    logic [7:0] wrData;
  } dioptm_req_t;

  // Mux port output: four select lines and the gain extension line.
  typedef struct packed {
    logic gainExt;
    logic [PORT_W-1:0] muxSel;
  } dioptm_mux_t;

  // Host timer setup group.
  typedef struct packed {
    logic load;
    logic [CNT_W-1:0] div1;
    logic [CNT_W-1:0] div2;
    logic [CNT_W-1:0] delayCnt;
    logic [CNT_W-1:0] stopCnt;
    logic [CNT_W-1:0] daDiv;
  } dioptm_tmr_t;
endpackage

// file: verilog/dioptm_top.sv
// Purpose: Digital ports, mux output port, trigger logic and pacer timers.
// Assumes: Pins are asynchronous and pass two flip-flops before use.
// Notes: Ports 0 (lines), 1 (mux), 2 (trigger) are addressed by rdPort/wrPort.
`timescale 1ns/1ps
module dioptm_top import dioptm_pkg::*; (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic nrst,
  // Host control.
  input wire logic swInit,
  input wire dioptm_req_t req,
  input wire dioptm_tmr_t tmr,
  input wire logic acqStart,
  input wire logic acqAbort,
  input wire logic trigNegEdge,
  input wire logic trigEnable,
  input wire logic sampleDone,
  // Host answers.
  output logic [7:0] rdData,
  output logic rdValid,
  output logic acqActive,
  output logic data_lost_event,
  // Pins.
  input wire logic [PORT_W-1:0] parallel_in_lines,
  input wire logic trigger_input_line,
  output logic [PORT_W-1:0] parallelOutLines,
  output logic [PORT_W-1:0] upper_mux_select_lines,
  output logic gain_extension_line,
  // Pacing.
  output logic adPace,
  output logic daPace
);
  typedef struct packed {
    logic [PORT_W-1:0] inMeta;
    logic [PORT_W-1:0] inSync;
    logic trgMeta;
    logic trgSync;
    logic trgPrev;
    logic [PORT_W-1:0] dout;
    dioptm_mux_t mux;
    logic [7:0] rdData;
    logic rdValid;
    dioptm_acq_t acq;
    logic [CNT_W-1:0] stopLeft;
    logic [3:0] oscCnt;
    logic initDone;
  } dioptm_st_t;

  dioptm_st_t s_q, s_d;
  logic oscTick;
  logic c1Pulse;
  logic c0Pulse;
  logic trigEdge;

  function automatic logic [7:0] rjust(input logic [PORT_W-1:0] v);
    rjust = {{(8-PORT_W){1'b0}}, v};
  endfunction

  assign oscTick = (s_q.oscCnt == 4'(OSC_DIV - 1));
  assign trigEdge = trigEnable && (trigNegEdge ? (s_q.trgPrev && !s_q.trgSync)
                                               : (!s_q.trgPrev && s_q.trgSync));

  ////////////////////////////////////////////////////////////////////////////
  // Counters 1 and 2 form the cascaded A/D pacer.
  dioptm_counter #(.W(CNT_W)) u_cnt1 (
    .sys_clk(sys_clk), .nrst(nrst), .init(swInit), .load(tmr.load),
    .loadVal(tmr.div1), .tick(oscTick), .pulse(c1Pulse));
  dioptm_counter #(.W(CNT_W)) u_cnt2 (
    .sys_clk(sys_clk), .nrst(nrst), .init(swInit), .load(tmr.load),
    .loadVal(tmr.div2), .tick(c1Pulse), .pulse(adPace));
  // Counter 0 times the trigger delay and stays internal.
  dioptm_counter #(.W(CNT_W)) u_cnt0 (
    .sys_clk(sys_clk), .nrst(nrst), .init(swInit), .load(tmr.load),
    .loadVal(tmr.delayCnt), .tick(s_q.acq == DIOPTM_DELAY && oscTick), .pulse(c0Pulse));
  // Extra counter paces the D/A.
  dioptm_counter #(.W(CNT_W)) u_cntDa (
    .sys_clk(sys_clk), .nrst(nrst), .init(swInit), .load(tmr.load),
    .loadVal(tmr.daDiv), .tick(oscTick), .pulse(daPace));

  ////////////////////////////////////////////////////////////////////////////
  // Port transfers, trigger and acquisition control.
  always_comb begin
    s_d = s_q;
    s_d.inMeta = parallel_in_lines;
    s_d.inSync = s_q.inMeta;
    s_d.trgMeta = trigger_input_line;
    s_d.trgSync = s_q.trgMeta;
    s_d.trgPrev = s_q.trgSync;
    s_d.oscCnt = oscTick ? 4'h0 : s_q.oscCnt + 4'h1;
    s_d.rdValid = req.rdReq;
    if (req.rdReq) begin
      case (req.rdPort)
        2'h0: s_d.rdData = rjust(s_q.inSync);
        2'h2: s_d.rdData = rjust({{(PORT_W-1){1'b0}}, s_q.trgSync});
        default: s_d.rdData = 8'h00;
      endcase
    end
    if (req.wrReq) begin
      case (req.wrPort)
        2'h0: s_d.dout = req.wrData[PORT_W-1:0];
        2'h1: begin
          if (s_q.acq == DIOPTM_IDLE) begin
            s_d.mux.muxSel = req.wrData[PORT_W-1:0];
            s_d.mux.gainExt = req.wrData[PORT_W];
          end
        end
        default: s_d.dout = s_q.dout;
      endcase
    end
    case (s_q.acq)
      DIOPTM_IDLE: begin
        if (acqStart && (!trigEnable || trigEdge)) begin
          s_d.acq = DIOPTM_DELAY;
          s_d.stopLeft = (tmr.stopCnt == CNT_ZERO) ? CNT_ONE : tmr.stopCnt;
        end
      end
      DIOPTM_DELAY: begin
        if (c0Pulse) begin
          s_d.acq = DIOPTM_RUN;
        end
      end
      DIOPTM_RUN: begin
        if (sampleDone) begin
          if (s_q.stopLeft == CNT_ONE) begin
            s_d.acq = DIOPTM_IDLE;
          end else begin
            s_d.stopLeft = s_q.stopLeft - CNT_ONE;
          end
        end
      end
      default: s_d.acq = DIOPTM_IDLE;
    endcase
    if (acqAbort) begin
      s_d.acq = DIOPTM_IDLE;
    end
    if (swInit) begin
      s_d.dout = OUT_RST;
      s_d.mux = '0;
      s_d.acq = DIOPTM_IDLE;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdData = s_q.rdData;
  assign rdValid = s_q.rdValid;
  assign acqActive = (s_q.acq != DIOPTM_IDLE);
  assign data_lost_event = 1'b0;
  assign parallelOutLines = s_q.dout;
  assign upper_mux_select_lines = s_q.mux.muxSel;
  assign gain_extension_line = s_q.mux.gainExt;
endmodule // dioptm_top
